// ===== riar_pkg.sv
// Constants for the remote I2C alias remap table
//
// Behaviour
// - Each target entry holds 7-bit address, resets zero
// - Each alias entry holds 7-bit address, resets zero
// - Matched alias is swapped for target before forwarding
// - Substitute comes from target of same index
// - Zero target entry blocks forwarding for that index
// - Zero alias entry matches nothing for that index
// - Port select steers target entry accesses to port 1
// - Port select steers alias entry accesses to port 1
package riar_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TARGET_5 = 8'h74;
  localparam logic [7:0] IDX_TARGET_6 = 8'h75;
  localparam logic [7:0] IDX_TARGET_7 = 8'h76;
  localparam logic [7:0] IDX_ALIAS_1 = 8'h77;
  localparam logic [7:0] IDX_ALIAS_2 = 8'h78;
  localparam logic [7:0] IDX_PORT_CTRL = 8'h7E;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int PORT_SEL_BIT = 0;
  localparam logic [6:0] ENTRY_RESET = 7'h00;
  localparam logic [6:0] ENTRY_OFF = 7'h00;
  localparam logic PORT_SEL_RESET = 1'b0;
  localparam int NUM_ENTRIES = 7;
  localparam int NUM_PORTS = 2;
  localparam int APB_ADDR_W = 12;

endpackage

// ===== riar_match.sv
// Alias lookup across all seven entries of one link port
`timescale 1ns/10ps
module riar_match (
  // Table of the selected port, entry 1 in the low bits
  input wire logic [48:0] i_alias_flat,
  input wire logic [48:0] i_target_flat,
  // Incoming address byte
  input wire logic [7:0] i_addr_byte,
  // Lookup result
  output logic o_hit,
  output logic [2:0] o_index,
  output logic [7:0] o_remap_byte
);

  logic [6:0] hit_vec;

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_entry
      assign hit_vec[g] =
        (i_alias_flat[g*7 +: 7] != riar_pkg::ENTRY_OFF) &&
        (i_target_flat[g*7 +: 7] != riar_pkg::ENTRY_OFF) &&
        (i_alias_flat[g*7 +: 7] == i_addr_byte[7:1]);
    end
  endgenerate

  // Lowest matching index wins
  always_comb begin
    o_hit = 1'b0;
    o_index = 3'h0;
    o_remap_byte = 8'h00;
    for (int i = 6; i >= 0; i--) begin
      if (hit_vec[i]) begin
        o_hit = 1'b1;
        o_index = 3'(i + 1);
        o_remap_byte = {i_target_flat[i*7 +: 7], i_addr_byte[0]};
      end
    end
  end

endmodule

// ===== riar_top.sv
// Alias remap table with APB register access and address translator
`timescale 1ns/10ps
module riar_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [riar_pkg::APB_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Entries held elsewhere in the register file, per port
  input wire logic [27:0] i_p0_target_1to4,
  input wire logic [27:0] i_p1_target_1to4,
  input wire logic [34:0] i_p0_alias_3to7,
  input wire logic [34:0] i_p1_alias_3to7,
  // Address request from the local I2C controller
  input wire logic i_req_valid,
  input wire logic i_req_port,
  input wire logic [7:0] i_req_addr_byte,
  // Forwarded address toward the control channel
  output logic o_fwd_valid,
  output logic [7:0] o_fwd_addr_byte,
  output logic [2:0] o_fwd_index,
  output logic o_fwd_port,
  output logic o_req_nomatch,
  // Port select state
  output logic o_second_port_select
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [6:0] target_q [riar_pkg::NUM_PORTS][3];
  logic [6:0] alias_q [riar_pkg::NUM_PORTS][2];
  logic port_sel_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic [7:0] idx;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [7:0] rd_byte;

  assign idx = i_paddr[9:2];
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
  assign mapped = (i_paddr[1:0] == 2'h0) &&
                  (i_paddr[riar_pkg::APB_ADDR_W-1:10] == '0) &&
                  ((idx >= riar_pkg::IDX_TARGET_5 &&
                    idx <= riar_pkg::IDX_ALIAS_2) ||
                   idx == riar_pkg::IDX_PORT_CTRL);

  // ----------------------------------------------------------------
  // Table writes, one copy per link port
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < riar_pkg::NUM_PORTS; p++) begin : g_port
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          for (int k = 0; k < 3; k++) begin
            target_q[p][k] <= riar_pkg::ENTRY_RESET;
          end
          for (int k = 0; k < 2; k++) begin
            alias_q[p][k] <= riar_pkg::ENTRY_RESET;
          end
        end else if (wr_en && (port_sel_q == 1'(p))) begin
          case (idx)
            riar_pkg::IDX_TARGET_5: begin
              target_q[p][0] <= i_pwdata[riar_pkg::ADDR_MSB:
                                         riar_pkg::ADDR_LSB];
            end
            riar_pkg::IDX_TARGET_6: begin
              target_q[p][1] <= i_pwdata[riar_pkg::ADDR_MSB:
                                         riar_pkg::ADDR_LSB];
            end
            riar_pkg::IDX_TARGET_7: begin
              target_q[p][2] <= i_pwdata[riar_pkg::ADDR_MSB:
                                         riar_pkg::ADDR_LSB];
            end
            riar_pkg::IDX_ALIAS_1: begin
              alias_q[p][0] <= i_pwdata[riar_pkg::ADDR_MSB:
                                        riar_pkg::ADDR_LSB];
            end
            riar_pkg::IDX_ALIAS_2: begin
              alias_q[p][1] <= i_pwdata[riar_pkg::ADDR_MSB:
                                        riar_pkg::ADDR_LSB];
            end
            default: begin
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port select control
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      port_sel_q <= riar_pkg::PORT_SEL_RESET;
    end else if (wr_en && idx == riar_pkg::IDX_PORT_CTRL) begin
      port_sel_q <= i_pwdata[riar_pkg::PORT_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read mux, reserved bit 0 reads zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      riar_pkg::IDX_TARGET_5: begin
        rd_byte = {target_q[port_sel_q][0], 1'b0};
      end
      riar_pkg::IDX_TARGET_6: begin
        rd_byte = {target_q[port_sel_q][1], 1'b0};
      end
      riar_pkg::IDX_TARGET_7: begin
        rd_byte = {target_q[port_sel_q][2], 1'b0};
      end
      riar_pkg::IDX_ALIAS_1: begin
        rd_byte = {alias_q[port_sel_q][0], 1'b0};
      end
      riar_pkg::IDX_ALIAS_2: begin
        rd_byte = {alias_q[port_sel_q][1], 1'b0};
      end
      riar_pkg::IDX_PORT_CTRL: begin
        rd_byte = {7'h00, port_sel_q};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one access cycle, captured in setup
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped;
        prdata_q <= (mapped && !i_pwrite) ? {24'h00_0000, rd_byte} :
                    32'h0000_0000;
      end else if (pready_q) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;
  assign o_second_port_select = port_sel_q;

  // ----------------------------------------------------------------
  // Address translation
  // ----------------------------------------------------------------
  logic [48:0] alias_flat;
  logic [48:0] target_flat;
  logic hit;
  logic [2:0] hit_idx;
  logic [7:0] remap_byte;

  always_comb begin
    if (i_req_port) begin
      alias_flat = {i_p1_alias_3to7, alias_q[1][1], alias_q[1][0]};
      target_flat = {target_q[1][2], target_q[1][1], target_q[1][0],
                     i_p1_target_1to4};
    end else begin
      alias_flat = {i_p0_alias_3to7, alias_q[0][1], alias_q[0][0]};
      target_flat = {target_q[0][2], target_q[0][1], target_q[0][0],
                     i_p0_target_1to4};
    end
  end

  riar_match u_match (
    .i_alias_flat(alias_flat),
    .i_target_flat(target_flat),
    .i_addr_byte(i_req_addr_byte),
    .o_hit(hit),
    .o_index(hit_idx),
    .o_remap_byte(remap_byte)
  );

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fwd_valid <= 1'b0;
      o_fwd_addr_byte <= 8'h00;
      o_fwd_index <= 3'h0;
      o_fwd_port <= 1'b0;
      o_req_nomatch <= 1'b0;
    end else begin
      o_fwd_valid <= i_req_valid && hit;
      o_req_nomatch <= i_req_valid && !hit;
      if (i_req_valid && hit) begin
        o_fwd_addr_byte <= remap_byte;
        o_fwd_index <= hit_idx;
        o_fwd_port <= i_req_port;
      end
    end
  end

endmodule

// ===== riar_asserts.sv
// Checker for the alias remap block
`timescale 1ns/10ps
module riar_asserts (
  // Clock, reset and APB
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [riar_pkg::APB_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Requests and results
  input wire logic i_req_valid,
  input wire logic i_req_port,
  input wire logic [7:0] i_req_addr_byte,
  input wire logic o_fwd_valid,
  input wire logic [7:0] o_fwd_addr_byte,
  input wire logic o_fwd_port,
  input wire logic o_req_nomatch,
  input wire logic o_second_port_select
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence sel_wr_s;
    setup_s ##1 i_psel && i_penable && i_pwrite && i_paddr == 12'h1F8;
  endsequence
  apb_ready_a: assert property (setup_s |=> o_pready ##1 !o_pready)
    else $error("pready not a single access cycle");
  rd_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero outside access");
  err_qual_a: assert property (o_pslverr |-> o_pready)
    else $error("error response outside access");
  port_sel_a: assert property (
    sel_wr_s |=> o_second_port_select == $past(i_pwdata[0]))
    else $error("port select not written");
  one_answer_a: assert property (
    i_req_valid |=> o_fwd_valid != o_req_nomatch)
    else $error("request without exactly one answer");
  no_answer_a: assert property (!i_req_valid |=> !o_fwd_valid && !o_req_nomatch)
    else $error("answer without request");
  rw_keep_a: assert property (
    i_req_valid ##1 o_fwd_valid |->
    o_fwd_addr_byte[0] == $past(i_req_addr_byte[0]) &&
    o_fwd_port == $past(i_req_port))
    else $error("direction bit or port lost");
  zero_tgt_a: assert property (o_fwd_valid |-> o_fwd_addr_byte[7:1] != 7'h00)
    else $error("forward to zero target");
  zero_alias_a: assert property (
    i_req_valid && i_req_addr_byte[7:1] == 7'h00 |=> o_req_nomatch)
    else $error("zero address matched");
  hold_a: assert property (!o_fwd_valid |-> $stable(o_fwd_addr_byte))
    else $error("forward byte moved without hit");
endmodule
bind riar_top riar_asserts riar_asserts_inst (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .i_req_valid(i_req_valid),
  .i_req_port(i_req_port),
  .i_req_addr_byte(i_req_addr_byte),
  .o_fwd_valid(o_fwd_valid),
  .o_fwd_addr_byte(o_fwd_addr_byte),
  .o_fwd_port(o_fwd_port),
  .o_req_nomatch(o_req_nomatch),
  .o_second_port_select(o_second_port_select)
);

// ===== riar_ctrl_model.sv
// Local I2C controller model issuing address requests
`timescale 1ns/10ps
module riar_ctrl_model (
  // Clock and request
  input wire logic i_core_clk,
  output logic o_req_valid,
  output logic o_req_port,
  output logic [7:0] o_req_addr_byte
);
  initial begin
    o_req_valid = 1'h0;
    o_req_port = 1'h0;
    o_req_addr_byte = 8'h00;
  end
  // One-cycle request, address inverted once released
  task automatic send(input logic p, input logic [7:0] a);
    @(posedge i_core_clk);
    o_req_valid <= 1'h1;
    o_req_port <= p;
    o_req_addr_byte <= a;
    @(posedge i_core_clk);
    o_req_valid <= 1'h0;
    o_req_addr_byte <= ~a;
  endtask
endmodule

// ===== riar_top_test.sv
// Testbench for the alias remap block
`timescale 1ns/10ps
module riar_top_test;
  logic clk, rst, psel, pen, pwr, rdy, err, e, rv, rp, fv, fp, nm, ps;
  logic [riar_pkg::APB_ADDR_W-1:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [7:0] ra, fa;
  logic [2:0] fi;
  logic [27:0] t0 = {7'h04, 7'h03, 7'h12, 7'h11};
  logic [27:0] t1 = {7'h04, 7'h03, 7'h12, 7'h13};
  logic [34:0] a0 = {7'h27, 7'h26, 7'h25, 7'h00, 7'h00};
  int errors, cmp_count;
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  riar_top riar_top_inst (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_p0_target_1to4(t0), .i_p1_target_1to4(t1), .i_p0_alias_3to7(a0),
    .i_p1_alias_3to7(a0), .i_req_valid(rv), .i_req_port(rp),
    .i_req_addr_byte(ra), .o_fwd_valid(fv), .o_fwd_addr_byte(fa),
    .o_fwd_index(fi), .o_fwd_port(fp), .o_req_nomatch(nm),
    .o_second_port_select(ps));
  riar_ctrl_model ctl (.i_core_clk(clk), .o_req_valid(rv),
    .o_req_port(rp), .o_req_addr_byte(ra));
  task automatic complete_run(input bit t);
    if (t) errors++;
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= {2'h0, i, 2'h0};
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'h1 && k < 20);
    if (k >= 20) complete_run(1);
    rd = prd;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic req(input logic p, input logic [7:0] a, input logic h,
      input logic [7:0] x, input logic [2:0] i);
    ctl.send(p, a);
    #1;
    chk("fwd_valid", 32'(h), 32'(fv));
    chk("nomatch", 32'(!h), 32'(nm));
    if (h) begin
      chk("fwd_byte", 32'(x), 32'(fa));
      chk("fwd_index", 32'(i), 32'(fi));
      chk("fwd_port", 32'(p), 32'(fp));
    end
  endtask
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    pen = 1'h0;
    pwr = 1'h0;
    pa = 12'h000;
    pwd = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int j = 0; j < 5; j++) begin
      apb(1'h0, 8'h74 + 8'(j), 32'h0);
      chk("reset", 32'h0, rd);
    end
    apb(1'h0, 8'h7E, 32'h0);
    chk("psel_rst", 32'h0, rd);
    apb(1'h0, 8'h7F, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    apb(1'h1, 8'h74, 32'hA1);
    apb(1'h1, 8'h75, 32'hA2);
    apb(1'h1, 8'h76, 32'h0);
    apb(1'h1, 8'h77, 32'h62);
    apb(1'h1, 8'h78, 32'h0);
    apb(1'h0, 8'h74, 32'h0);
    chk("tgt5", 32'hA0, rd);
    apb(1'h0, 8'h77, 32'h0);
    chk("alias1", 32'h62, rd);
    req(1'h0, 8'h4B, 1'h1, 8'hA1, 3'h5);
    req(1'h0, 8'h4C, 1'h1, 8'hA2, 3'h6);
    req(1'h0, 8'h4E, 1'h0, 8'h00, 3'h0);
    req(1'h0, 8'h63, 1'h1, 8'h23, 3'h1);
    req(1'h0, 8'h00, 1'h0, 8'h00, 3'h0);
    req(1'h0, 8'h24, 1'h0, 8'h00, 3'h0);
    apb(1'h1, 8'h7E, 32'h1);
    apb(1'h0, 8'h7E, 32'h0);
    chk("psel_rd", 32'h1, rd);
    chk("psel_pin", 32'h1, 32'(ps));
    apb(1'h1, 8'h74, 32'hC0);
    apb(1'h1, 8'h77, 32'h40);
    apb(1'h0, 8'h74, 32'h0);
    chk("p1_tgt5", 32'hC0, rd);
    apb(1'h0, 8'h77, 32'h0);
    chk("p1_alias1", 32'h40, rd);
    req(1'h1, 8'h4B, 1'h1, 8'hC1, 3'h5);
    req(1'h1, 8'h40, 1'h1, 8'h26, 3'h1);
    req(1'h0, 8'h40, 1'h0, 8'h00, 3'h0);
    apb(1'h1, 8'h7E, 32'h0);
    apb(1'h0, 8'h74, 32'h0);
    chk("p0_tgt5", 32'hA0, rd);
    chk("psel_pin0", 32'h0, 32'(ps));
    apb(1'h0, 8'h77, 32'h0);
    chk("p0_alias1", 32'h62, rd);
    complete_run(0);
  end
endmodule
